// ---- afs_pkg.sv ----
// Shared constants for the alert and fault status flag registers
package afs_pkg;

  // Register access
  localparam int unsigned REG_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ALERT_OFS = 8'h20;
  localparam logic [7:0] FAULT_OFS = 8'h21;

  // Alert register field positions
  localparam int unsigned ALERT_UNASSIGNED_BIT = 7;
  localparam int unsigned ALERT_PARITY_BIT = 6;
  localparam int unsigned ALERT_ECC_BIT = 5;
  localparam int unsigned ALERT_FORCE_BIT = 4;
  localparam int unsigned ALERT_THERMAL_BIT = 3;
  localparam int unsigned ALERT_SLEEP_BIT = 2;
  localparam int unsigned ALERT_OTTWO_BIT = 1;
  localparam int unsigned ALERT_OTONE_BIT = 0;

  // Fault register field positions
  localparam int unsigned FAULT_CONSIST_BIT = 5;
  localparam int unsigned FAULT_FORCE_BIT = 4;
  localparam int unsigned FAULT_POR_BIT = 3;
  localparam int unsigned FAULT_CRC_BIT = 2;
  localparam int unsigned FAULT_UNDER_BIT = 1;
  localparam int unsigned FAULT_OVER_BIT = 0;

  // Sticky flag banks, packed without the special bits
  localparam int unsigned ALERT_STICKY_W = 6;
  localparam int unsigned FAULT_STICKY_W = 5;
  localparam int unsigned FAULT_STICKY_POR = 3;

  // Reset values
  localparam logic [7:0] ALERT_RST = 8'h80;
  localparam logic [7:0] FAULT_RST = 8'h08;
  localparam logic [5:0] ALERT_STICKY_RST = 6'h00;
  localparam logic [4:0] FAULT_STICKY_RST = 5'h08;
  localparam logic FORCE_RST = 1'b0;
  localparam logic UNASSIGNED_RST = 1'b1;

  // Clear sequence for the address-unassigned flag
  typedef enum logic [1:0] {
    AFS_CLR_IDLE = 2'b01,
    AFS_CLR_ARMED = 2'b10
  } afs_clr_state_t;

endpackage

// ---- afs_flag_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
// Bank of sticky flags, set by hardware, cleared by writing one
module afs_flag_bank #(
  parameter int unsigned WIDTH = 6,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] setVec,
  input wire logic [WIDTH-1:0] clrVec,
  output logic [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  // Per-bit next value, a set beats a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_comb begin
        flags_next[gi] = flags_reg[gi];
        if (clkEn) begin
          if (setVec[gi]) begin
            flags_next[gi] = 1'b1;
          end else if (clrVec[gi]) begin
            flags_next[gi] = 1'b0;
          end
        end
      end
    end
  endgenerate

  // Flag storage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_reg <= RST_VAL;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule // afs_flag_bank
`default_nettype wire

// ---- afs_status_flags.sv ----
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Alert bit 7 sets while address is unassigned; reads 1 after reset.
// - Bit 7 clears only after address assigned, then host writes 1, then 0.
// - Alert bit 6 sets when protected config group parity is invalid.
// - Alert bit 5 sets on uncorrectable double-bit OTP error only.
// - Alert bit 4 is a force bit driving the alert output; resets to 0.
// - Alert bit 3 sets while thermal shutdown is active; resets to 0.
// - Alert bit 2 sets only on sleep entry, not while sleep stays on.
// - Alert bit 1 sets when input two exceeds its over-temperature threshold.
// - Alert bit 0 sets when input one exceeds its over-temperature threshold.
// - Fault flags clear by writing one; fault bit 4 holds written value.
// - Alert flags except bit 7 clear by writing one; alert bit 4 holds written value.
// - Fault bit 5 sets when internal register consistency check fails.
// - Fault bit 4 is a force bit driving the fault output; resets to 0.
// - Fault bit 3 is set by power-on reset until host clears it.
// - Fault bit 2 sets on CRC error in last received packet.
// - Fault bit 1 sets when any cell is below undervoltage threshold.
// - Fault bit 0 sets when a cell overvoltage condition is detected.
module afs_status_flags (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [afs_pkg::ADDR_W-1:0] regAddr,
  input wire logic [afs_pkg::REG_W-1:0] regWrData,
  output logic [afs_pkg::REG_W-1:0] regRdData,
  input wire logic addrAssigned,
  input wire logic parityInvalid,
  input wire logic eccDoubleErr,
  input wire logic thermalShutdown,
  input wire logic sleepActive,
  input wire logic overtempInputOne,
  input wire logic overtempInputTwo,
  input wire logic consistencyFail,
  input wire logic crcError,
  input wire logic cellUndervoltage,
  input wire logic cellOvervoltage,
  output logic alertOut,
  output logic faultOut
);
  import afs_pkg::*;

  logic alertWr;
  logic faultWr;
  logic mappedRd;
  logic sleepRise;
  logic [ALERT_STICKY_W-1:0] alertSet;
  logic [ALERT_STICKY_W-1:0] alertClr;
  logic [ALERT_STICKY_W-1:0] alertSticky;
  logic [FAULT_STICKY_W-1:0] faultSet;
  logic [FAULT_STICKY_W-1:0] faultClr;
  logic [FAULT_STICKY_W-1:0] faultSticky;
  logic [REG_W-1:0] alertView;
  logic [REG_W-1:0] faultView;

  logic addrFlag_reg;
  logic addrFlag_next;
  afs_clr_state_t clrState_reg;
  afs_clr_state_t clrState_next;
  logic sleepPrev_reg;
  logic sleepPrev_next;
  logic alertForce_reg;
  logic alertForce_next;
  logic faultForce_reg;
  logic faultForce_next;
  logic alertOut_reg;
  logic alertOut_next;
  logic faultOut_reg;
  logic faultOut_next;
  logic [REG_W-1:0] rdData_reg;
  logic [REG_W-1:0] rdData_next;

  // Register decode
  assign alertWr = regWrEn && (regAddr == ALERT_OFS);
  assign faultWr = regWrEn && (regAddr == FAULT_OFS);
  assign mappedRd = (regAddr == ALERT_OFS) || (regAddr == FAULT_OFS);

  // Sleep entry edge, not the level
  assign sleepRise = sleepActive && !sleepPrev_reg;

  // Alert sticky sources, packed high to low
  assign alertSet = {
    parityInvalid,
    eccDoubleErr,
    thermalShutdown,
    sleepRise,
    overtempInputTwo,
    overtempInputOne
  };
  // Write one to clear, force bit and bit 7 excluded
  assign alertClr = alertWr ? {regWrData[6:5], regWrData[3:0]} : '0;

  // Fault sticky sources, reset itself sets the power-on flag
  assign faultSet = {
    consistencyFail,
    1'b0,
    crcError,
    cellUndervoltage,
    cellOvervoltage
  };
  assign faultClr = faultWr ? {regWrData[5], regWrData[3:0]} : '0;

  // Alert sticky flags
  afs_flag_bank #(
    .WIDTH(ALERT_STICKY_W),
    .RST_VAL(ALERT_STICKY_RST)
  ) u_alert_bank (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .setVec(alertSet),
    .clrVec(alertClr),
    .flags(alertSticky)
  );

  // Fault sticky flags, power-on flag preset
  afs_flag_bank #(
    .WIDTH(FAULT_STICKY_W),
    .RST_VAL(FAULT_STICKY_RST)
  ) u_fault_bank (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .setVec(faultSet),
    .clrVec(faultClr),
    .flags(faultSticky)
  );

  // Register images as read by the host
  assign alertView = {addrFlag_reg, alertSticky[5:4], alertForce_reg, alertSticky[3:0]};
  assign faultView = {2'b00, faultSticky[4], faultForce_reg, faultSticky[3:0]};

  // Address-unassigned flag and its two-write clear sequence
  always_comb begin
    addrFlag_next = addrFlag_reg;
    clrState_next = clrState_reg;
    if (clkEn) begin
      if (!addrAssigned) begin
        addrFlag_next = 1'b1;
        clrState_next = AFS_CLR_IDLE;
      end else if (alertWr) begin
        case (clrState_reg)
          AFS_CLR_IDLE: begin
            if (regWrData[ALERT_UNASSIGNED_BIT]) begin
              clrState_next = AFS_CLR_ARMED;
            end
          end
          AFS_CLR_ARMED: begin
            if (!regWrData[ALERT_UNASSIGNED_BIT]) begin
              addrFlag_next = 1'b0;
              clrState_next = AFS_CLR_IDLE;
            end
          end
          default: begin
            clrState_next = AFS_CLR_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addrFlag_reg <= UNASSIGNED_RST;
      clrState_reg <= AFS_CLR_IDLE;
    end else begin
      addrFlag_reg <= addrFlag_next;
      clrState_reg <= clrState_next;
    end
  end

  // Force bits, sleep history, outputs and read data
  always_comb begin
    sleepPrev_next = sleepPrev_reg;
    alertForce_next = alertForce_reg;
    faultForce_next = faultForce_reg;
    alertOut_next = alertOut_reg;
    faultOut_next = faultOut_reg;
    rdData_next = rdData_reg;
    if (clkEn) begin
      sleepPrev_next = sleepActive;
      if (alertWr) begin
        alertForce_next = regWrData[ALERT_FORCE_BIT];
      end
      if (faultWr) begin
        faultForce_next = regWrData[FAULT_FORCE_BIT];
      end
      alertOut_next = |alertView;
      faultOut_next = |faultView;
      if (regRdEn) begin
        if (regAddr == ALERT_OFS) begin
          rdData_next = alertView;
        end else if (regAddr == FAULT_OFS) begin
          rdData_next = faultView;
        end else begin
          rdData_next = '0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleepPrev_reg <= 1'b0;
      alertForce_reg <= FORCE_RST;
      faultForce_reg <= FORCE_RST;
      alertOut_reg <= 1'b1;
      faultOut_reg <= 1'b1;
      rdData_reg <= '0;
    end else begin
      sleepPrev_reg <= sleepPrev_next;
      alertForce_reg <= alertForce_next;
      faultForce_reg <= faultForce_next;
      alertOut_reg <= alertOut_next;
      faultOut_reg <= faultOut_next;
      rdData_reg <= rdData_next;
    end
  end

  // Output drive
  assign alertOut = alertOut_reg;
  assign faultOut = faultOut_reg;
  assign regRdData = rdData_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_unassigned_tracks: assert property (
    clkEn && !addrAssigned |=> addrFlag_reg
  ) else $error("unassigned flag not set while address missing");

  a_unassigned_single: assert property (
    clkEn && addrFlag_reg && clrState_reg == AFS_CLR_IDLE && alertWr
      && !regWrData[ALERT_UNASSIGNED_BIT] |=> addrFlag_reg
  ) else $error("unassigned flag cleared without prior one write");

  a_unassigned_twowr: assert property (
    clkEn && addrAssigned && alertWr && regWrData[ALERT_UNASSIGNED_BIT]
      ##1 addrAssigned
      ##1 (clkEn && addrAssigned && alertWr && !regWrData[ALERT_UNASSIGNED_BIT])
      |=> !addrFlag_reg
  ) else $error("unassigned flag kept after one then zero writes");

  a_parity_sets: assert property (
    clkEn && parityInvalid |=> alertView[ALERT_PARITY_BIT]
  ) else $error("parity flag missing");

  a_parity_output: assert property (
    clkEn && parityInvalid ##1 clkEn |=> alertOut
  ) else $error("alert output missing after parity flag");

  a_sleep_edge: assert property (
    clkEn && sleepActive && !sleepRise && alertSticky[2] && alertWr
      && regWrData[ALERT_SLEEP_BIT] ##1 (clkEn && sleepActive) |=> !alertSticky[2]
  ) else $error("sleep flag set again while sleep held");

  a_alert_force: assert property (
    clkEn && alertWr |=> alertForce_reg == $past(regWrData[ALERT_FORCE_BIT])
  ) else $error("alert force bit wrong");

  a_alert_forced_out: assert property (
    clkEn && alertForce_reg |=> alertOut
  ) else $error("alert output not asserted by force");

  a_fault_force: assert property (
    clkEn && faultWr && regWrData[FAULT_FORCE_BIT] ##1 clkEn |=> faultOut
  ) else $error("fault output not asserted by force");

  a_fault_forced: assert property (
    clkEn && faultWr |=> faultForce_reg == $past(regWrData[FAULT_FORCE_BIT])
  ) else $error("fault force bit wrong");

  a_sticky_hold: assert property (
    clkEn && faultSticky[FAULT_CRC_BIT] && !(faultWr && regWrData[FAULT_CRC_BIT])
      |=> faultSticky[FAULT_CRC_BIT]
  ) else $error("crc flag lost without clear");

  a_crc_sets: assert property (
    clkEn && crcError && faultWr && regWrData[FAULT_CRC_BIT] |=> faultView[FAULT_CRC_BIT]
  ) else $error("crc event lost against clear");

  a_outputs_quiet: assert property (
    clkEn && alertView == '0 |=> !alertOut
  ) else $error("alert output with no cause");

  a_unmapped_read: assert property (
    clkEn && regRdEn && !mappedRd |=> regRdData == '0
  ) else $error("unmapped read returned data");

  a_ecc_sets: assert property (
    clkEn && eccDoubleErr |=> alertView[ALERT_ECC_BIT]
  ) else $error("ecc flag missing");

  a_thermal_sets: assert property (
    clkEn && thermalShutdown |=> alertView[ALERT_THERMAL_BIT]
  ) else $error("thermal flag missing");

  a_ottwo_sets: assert property (
    clkEn && overtempInputTwo |=> alertView[ALERT_OTTWO_BIT]
  ) else $error("input two overtemp flag missing");

  a_otone_sets: assert property (
    clkEn && overtempInputOne |=> alertView[ALERT_OTONE_BIT]
  ) else $error("input one overtemp flag missing");

  a_consist_sets: assert property (
    clkEn && consistencyFail |=> faultView[FAULT_CONSIST_BIT]
  ) else $error("consistency flag missing");

  a_under_sets: assert property (
    clkEn && cellUndervoltage |=> faultView[FAULT_UNDER_BIT]
  ) else $error("undervoltage flag missing");

  a_over_sets: assert property (
    clkEn && cellOvervoltage |=> faultView[FAULT_OVER_BIT]
  ) else $error("overvoltage flag missing");

  a_por_hold: assert property (
    clkEn && faultView[FAULT_POR_BIT] && !(faultWr && regWrData[FAULT_POR_BIT])
      |=> faultView[FAULT_POR_BIT]
  ) else $error("power-on flag lost without clear");

  a_alert_hold: assert property (
    clkEn && alertView[ALERT_OTONE_BIT] && !(alertWr && regWrData[ALERT_OTONE_BIT])
      |=> alertView[ALERT_OTONE_BIT]
  ) else $error("input one flag lost without clear");

  a_fault_quiet: assert property (
    clkEn && faultView == '0 |=> !faultOut
  ) else $error("fault output with no cause");

  a_read_image: assert property (
    clkEn && regRdEn && regAddr == ALERT_OFS |=> regRdData == $past(alertView)
  ) else $error("alert read differs from image");

  a_enable_freeze: assert property (
    !clkEn |=> $stable(alertView) && $stable(faultView)
      && $stable(regRdData) && $stable(alertOut) && $stable(faultOut)
  ) else $error("state changed while clock enable low");

  c_unassigned_clear: cover property (
    addrFlag_reg ##1 !addrFlag_reg
  );
  c_por_cleared: cover property (
    faultSticky[FAULT_STICKY_POR] ##1 !faultSticky[FAULT_STICKY_POR]
  );
  c_sleep_entry: cover property (
    clkEn && sleepRise ##1 alertSticky[2]
  );
  c_fault_force: cover property (
    faultForce_reg && faultOut
  );
  c_alert_force: cover property (
    alertForce_reg && alertOut
  );

endmodule // afs_status_flags
`default_nettype wire

// ---- afs_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host side of the register port, single-cycle strobes
module afs_host_model (
  input wire logic clk,
  output logic regWrEn,
  output logic regRdEn,
  output logic [afs_pkg::ADDR_W-1:0] regAddr,
  output logic [afs_pkg::REG_W-1:0] regWrData
);
  import afs_pkg::*;
  // Idle bus at time zero
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  // One write; flags are cleared by writing one to them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
    regWrData = ~d; // Stale data not left on the bus
  endtask
  // One read strobe
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    regAddr = ~a;
  endtask
endmodule // afs_host_model
`default_nettype wire

// ---- alert_fault_status_flags_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module alert_fault_status_flags_tb;
  import afs_pkg::*;
  logic clk, sys_rst, clkEn, addrAssigned;
  logic [9:0] src;
  wire logic regWrEn, regRdEn, alertOut, faultOut;
  wire logic [7:0] regAddr, regWrData, regRdData;
  logic [7:0] mSa, mSf, mRd, aImg, fImg;
  logic mFa, mFf, mUn, mArm, mSlp, mAo, mFo;
  int fail_count = 0;
  int compares = 0;
  integer seed = 32'h9e65318f;

  afs_host_model host_u (.clk(clk), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData));
  afs_status_flags dut_u (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .addrAssigned(addrAssigned),
    .parityInvalid(src[9]), .eccDoubleErr(src[8]), .thermalShutdown(src[7]),
    .sleepActive(src[6]), .overtempInputTwo(src[5]), .overtempInputOne(src[4]),
    .consistencyFail(src[3]), .crcError(src[2]), .cellUndervoltage(src[1]),
    .cellOvervoltage(src[0]), .alertOut(alertOut), .faultOut(faultOut));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Register images of the model
  assign aImg = mSa | {mUn, 2'b00, mFa, 4'h0};
  assign fImg = mSf | {3'b000, mFf, 4'h0};

  // Reference model of both flag registers
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mSa = 8'h00;
      mSf = 8'h08;
      {mFa, mFf, mArm, mSlp, mRd} = '0;
      {mUn, mAo, mFo} = 3'b111;
    end else if (clkEn) begin
      mAo = |aImg;
      mFo = |fImg;
      if (regRdEn) begin
        mRd = (regAddr == ALERT_OFS) ? aImg : (regAddr == FAULT_OFS) ? fImg : 8'h00;
      end
      if (regWrEn && regAddr == ALERT_OFS) begin
        mSa = mSa & ~regWrData;
        mFa = regWrData[4];
        if (addrAssigned && regWrData[7]) begin
          mArm = 1'b1;
        end else if (addrAssigned && mArm) begin
          mUn = 1'b0;
          mArm = 1'b0;
        end
      end
      if (regWrEn && regAddr == FAULT_OFS) begin
        mSf = mSf & ~regWrData;
        mFf = regWrData[4];
      end
      // Set wins over clear; sleep sets on its rising edge only
      mSa = mSa | {1'b0, src[9:8], 1'b0, src[7], src[6] & ~mSlp, src[5:4]};
      mSf = mSf | {2'b00, src[3], 2'b00, src[2:0]};
      mSlp = src[6];
      if (!addrAssigned) begin
        mUn = 1'b1;
        mArm = 1'b0; // Losing the address drops a pending clear
      end
    end
  end

  task automatic chkReg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD reg %h exp %h got %h", a, e, g);
    end
  endtask

  task automatic chkPin(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %b got %b", n, e, g);
    end
  endtask

  task automatic rdChk(input logic [7:0] a);
    host_u.rd(a);
    chkReg(a, mRd, regRdData);
  endtask

  task automatic endTest(input string n);
    $display("test %s done", n);
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Output pins checked every cycle
  always @(negedge clk) begin
    if (!sys_rst) begin
      chkPin("alertOut", mAo, alertOut);
      chkPin("faultOut", mFo, faultOut);
    end
  end

  // Watchdog
  initial begin
    #500000;
    fail_count++;
    print_verdict();
  end

  // Test sequence
  initial begin
    clkEn = 1'b1;
    addrAssigned = 1'b0;
    src = '0;
    sys_rst = 1'b1;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    rdChk(ALERT_OFS);
    rdChk(FAULT_OFS);
    endTest("reset");
    host_u.wr(ALERT_OFS, 8'h80);
    host_u.wr(ALERT_OFS, 8'h00);
    rdChk(ALERT_OFS);
    addrAssigned = 1'b1;
    host_u.wr(ALERT_OFS, 8'h00);
    rdChk(ALERT_OFS);
    host_u.wr(ALERT_OFS, 8'h80);
    host_u.wr(ALERT_OFS, 8'h00);
    rdChk(ALERT_OFS);
    endTest("address");
    host_u.wr(FAULT_OFS, 8'h08);
    for (int i = 0; i < 4; i++) begin
      host_u.wr(i[0] ? FAULT_OFS : ALERT_OFS, (i < 2) ? 8'h10 : 8'h00);
      rdChk(i[0] ? FAULT_OFS : ALERT_OFS);
    end
    endTest("force");
    for (int i = 0; i < 10; i++) begin
      src[i] = 1'b1;
      @(negedge clk);
      src[i] = 1'b0;
      rdChk(ALERT_OFS);
      rdChk(FAULT_OFS);
      host_u.wr(ALERT_OFS, 8'h6f);
      host_u.wr(FAULT_OFS, 8'h2f);
      rdChk(i < 4 ? FAULT_OFS : ALERT_OFS);
    end
    endTest("sources");
    src[6] = 1'b1;
    src[7] = 1'b1;
    repeat (3) @(negedge clk);
    host_u.wr(ALERT_OFS, 8'h0c);
    repeat (3) @(negedge clk);
    rdChk(ALERT_OFS);
    src[7:6] = 2'b00;
    host_u.wr(ALERT_OFS, 8'h08);
    rdChk(ALERT_OFS);
    endTest("sleep");
    clkEn = 1'b0;
    src[2] = 1'b1;
    host_u.wr(FAULT_OFS, 8'h10);
    src[2] = 1'b0;
    clkEn = 1'b1;
    rdChk(FAULT_OFS);
    host_u.wr(8'h22, 8'hff);
    rdChk(8'h22);
    rdChk(FAULT_OFS);
    endTest("refused");
    // Reset in mid-run, then lose and regain the address
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    rdChk(FAULT_OFS);
    rdChk(ALERT_OFS);
    addrAssigned = 1'b0;
    host_u.wr(ALERT_OFS, 8'h80);
    addrAssigned = 1'b1;
    host_u.wr(ALERT_OFS, 8'h00);
    rdChk(ALERT_OFS);
    host_u.wr(ALERT_OFS, 8'h80);
    host_u.wr(ALERT_OFS, 8'h00);
    rdChk(ALERT_OFS);
    endTest("rerun");
    repeat (1500) begin
      src = 10'($random(seed) & $random(seed) & $random(seed));
      clkEn = ($random(seed) & 7) != 0;
      if ($random(seed) & 1) begin
        host_u.wr(8'h20 | 8'($random(seed) & 1), 8'($random(seed)));
      end
      rdChk(8'h20 | 8'($random(seed) & 1));
    end
    endTest("random");
    print_verdict();
  end
endmodule // alert_fault_status_flags_tb
`default_nettype wire
